// ### rtl/bbe_pkg.sv
// shared constants for the beam blanking evaluator
package bbe_pkg;
  localparam int unsigned NUM_BEAMS      = 32;
  localparam int unsigned AW             = 4;
  // register word offsets (byte address = 4 * index)
  localparam logic [AW-1:0] REG_CTRL     = 4'h0;
  localparam logic [AW-1:0] REG_STATUS   = 4'h1;
  localparam logic [AW-1:0] REG_IRQ_STAT = 4'h2;
  localparam logic [AW-1:0] REG_IRQ_MASK = 4'h3;
  localparam logic [AW-1:0] REG_TAUGHT   = 4'h4;
  localparam logic [AW-1:0] REG_BEAMS    = 4'h5;
  // control fields
  localparam int unsigned CTRL_FIXED     = 0;
  localparam int unsigned CTRL_EDGE      = 1;
  localparam int unsigned CTRL_FLOAT_LSB = 2;
  localparam int unsigned CTRL_GRID      = 4;
  localparam int unsigned CTRL_TEACH     = 8;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  // irq stat / mask bit positions
  localparam int unsigned EV_TRIP        = 0;
  localparam int unsigned EV_LOCK        = 1;
  localparam int unsigned EV_CFG_ERR     = 2;
  localparam int unsigned EV_TAUGHT      = 3;
  localparam int unsigned NUM_EV         = 4;
  localparam logic [NUM_EV-1:0] EV_ZERO  = 4'h0;
  // blanking indicator flash: 250 ms half period
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned FLASH_MS       = 250;
  localparam int unsigned FLASH_CYC      = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned FLASH_W        = 25;
endpackage : bbe_pkg

// ### rtl/bbe_flash.sv
// divider producing a one-cycle enable pulse for the blanking indicator
`timescale 1ns/100ps
module bbe_flash #(
  parameter int unsigned PERIOD = bbe_pkg::FLASH_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_run,
  output logic      o_tick
);
  logic [bbe_pkg::FLASH_W-1:0] cnt_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else if (cnt_q == bbe_pkg::FLASH_W'(PERIOD - 1)) begin
      cnt_q  <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule : bbe_flash

// ### rtl/bbe_evaluator.sv
// beam blanking evaluator with wishbone register access
// Summary of operation
// - first beam is never blanked
// - fixed blanking allows any number of regions
// - taught set change locks the outputs
// - only a new teach-in clears lockout
// - fixed blanking enable flashes blanking indicator
// - edge mode accepts object shifted one beam
// - edge mode accepts one beam fewer
// - edge mode errors on larger deviation
// - edge mode excludes fixed and floating
// - curtain floats up to two beams
// - fixed and floating may combine
// - floating tolerates configured interrupted count
// - grid floats at most one beam
// - grid floating needs its parameter
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
module bbe_evaluator #(
  parameter int unsigned FLASH_PERIOD = bbe_pkg::FLASH_CYC
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic [bbe_pkg::NUM_BEAMS-1:0] i_beam_blocked,
  input  wire logic                          i_wb_cyc,
  input  wire logic                          i_wb_stb,
  input  wire logic                          i_wb_we,
  input  wire logic [bbe_pkg::AW-1:0]        i_wb_adr,
  input  wire logic [31:0]                   i_wb_dat,
  input  wire logic [3:0]                    i_wb_sel,
  output logic      [31:0]                   o_wb_dat,
  output logic                               o_wb_ack,
  output logic                               o_safe_out,
  output logic                               o_blank_led,
  output logic                               o_irq
);
  localparam int unsigned N = bbe_pkg::NUM_BEAMS;
  typedef logic [N-1:0] bbe_vec_t;

  //////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] bbe_count(input bbe_vec_t v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < N; i++) begin
      c = c + {7'h00, v[i]};
    end
    return c;
  endfunction : bbe_count

  function automatic logic bbe_wr(input logic [bbe_pkg::AW-1:0] a, input logic [bbe_pkg::AW-1:0] r,
                                  input logic cyc, input logic stb, input logic we, input logic ack);
    return cyc && stb && we && !ack && (a == r);
  endfunction : bbe_wr

  //////////////////////////////////////////////////////////////////////
  // beam input synchroniser
  bbe_vec_t beam_s1_q;
  bbe_vec_t beam_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      beam_s1_q <= '0;
      beam_q    <= '0;
    end else begin
      beam_s1_q <= i_beam_blocked;
      beam_q    <= beam_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // control register
  logic [31:0] ctrl_q;
  logic        wr_ctrl;
  logic        rd_stat;
  logic        teach_req;

  assign wr_ctrl   = bbe_wr(i_wb_adr, bbe_pkg::REG_CTRL, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack);
  assign rd_stat   = i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack && (i_wb_adr == bbe_pkg::REG_IRQ_STAT);
  assign teach_req = wr_ctrl && i_wb_sel[1] && i_wb_dat[bbe_pkg::CTRL_TEACH];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= bbe_pkg::CTRL_RESET;
    end else if (wr_ctrl && i_wb_sel[0]) begin
      ctrl_q[7:0] <= i_wb_dat[7:0];
    end
  end

  logic       p_fixed;
  logic       p_edge;
  logic [1:0] p_float;
  logic       p_grid;
  logic       cfg_err;
  logic [1:0] float_lim;

  assign p_fixed = ctrl_q[bbe_pkg::CTRL_FIXED];
  assign p_edge  = ctrl_q[bbe_pkg::CTRL_EDGE];
  assign p_float = ctrl_q[bbe_pkg::CTRL_FLOAT_LSB +: 2];
  assign p_grid  = ctrl_q[bbe_pkg::CTRL_GRID];
  assign cfg_err = (p_edge && (p_fixed || (p_float != 2'd0))) || (p_grid && (p_fixed || p_edge))
                   || (p_float == 2'd3);
  assign float_lim = cfg_err ? 2'd0 : (p_grid ? ((p_float != 2'd0) ? 2'd1 : 2'd0) : p_float);

  //////////////////////////////////////////////////////////////////////
  // teach-in and lockout
  bbe_vec_t taught_q;
  logic     locked_q;
  logic     taught_v_q;
  logic     fixed_on;

  assign fixed_on = (p_fixed || p_edge) && !cfg_err && !p_grid;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      taught_q   <= '0;
      taught_v_q <= 1'b0;
    end else if (teach_req && fixed_on) begin
      taught_q   <= {beam_q[N-1:1], 1'b0};
      taught_v_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // evaluation
  bbe_vec_t fixed_mask;
  logic     fixed_bad;
  logic     edge_ok;
  logic     float_ok;
  bbe_vec_t extra;
  bbe_vec_t up_set;
  bbe_vec_t dn_set;
  logic [7:0] n_taught;
  logic [7:0] n_obj;

  assign n_taught = bbe_count(taught_q);
  assign up_set   = {taught_q[N-2:0], 1'b0};
  assign dn_set   = {1'b0, taught_q[N-1:1]};

  always_comb begin
    fixed_mask = '0;
    fixed_bad  = 1'b0;
    edge_ok    = 1'b1;
    n_obj      = 8'h00;
    if (fixed_on && p_fixed) begin
      fixed_mask = taught_q;
      fixed_bad  = ((beam_q & taught_q) != taught_q);
    end else if (fixed_on && p_edge) begin
      fixed_mask = taught_q | up_set | dn_set;
      n_obj      = bbe_count(beam_q & fixed_mask & ~bbe_vec_t'(1));
      // larger change is an error
      // object may spread into one edge beam, never into both
      edge_ok    = (n_taught != 8'h00) && ((n_obj == n_taught) || (n_obj + 8'h01 == n_taught))
                   && (((beam_q & up_set & ~taught_q) == '0) || ((beam_q & dn_set & ~taught_q) == '0))
                   && (n_obj != 8'h00);
      fixed_bad  = !edge_ok;
    end
    fixed_mask[0] = 1'b0;
  end

  assign extra    = beam_q & ~fixed_mask;
  assign float_ok = !extra[0] && (bbe_count(extra) <= {6'h00, float_lim});

  logic trip;
  assign trip = !float_ok || cfg_err;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      locked_q <= 1'b0;
    end else if (teach_req && fixed_on) begin
      locked_q <= 1'b0;
    end else if (fixed_on && taught_v_q && fixed_bad) begin
      locked_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_safe_out <= 1'b0;
    end else begin
      o_safe_out <= !trip && !locked_q && !(fixed_on && !taught_v_q);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // blanking indicator
  logic flash_tick;
  logic blank_act;

  assign blank_act = fixed_on || (float_lim != 2'd0);

  bbe_flash #(
    .PERIOD (FLASH_PERIOD)
  ) u_flash (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_run  (blank_act),
    .o_tick (flash_tick)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_blank_led <= 1'b0;
    end else if (!blank_act) begin
      o_blank_led <= 1'b0;
    end else if (flash_tick) begin
      o_blank_led <= !o_blank_led;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // interrupts
  logic [bbe_pkg::NUM_EV-1:0] ev;
  logic [bbe_pkg::NUM_EV-1:0] irq_stat_q;
  logic [bbe_pkg::NUM_EV-1:0] irq_mask_q;
  logic                       safe_d1_q;
  logic                       lock_d1_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      safe_d1_q <= 1'b0;
      lock_d1_q <= 1'b0;
    end else begin
      safe_d1_q <= o_safe_out;
      lock_d1_q <= locked_q;
    end
  end

  always_comb begin
    ev                      = bbe_pkg::EV_ZERO;
    ev[bbe_pkg::EV_TRIP]    = safe_d1_q && !o_safe_out;
    ev[bbe_pkg::EV_LOCK]    = locked_q && !lock_d1_q;
    ev[bbe_pkg::EV_CFG_ERR] = cfg_err;
    ev[bbe_pkg::EV_TAUGHT]  = teach_req && fixed_on;
  end

  // set wins over read-clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat_q <= bbe_pkg::EV_ZERO;
    end else begin
      irq_stat_q <= (rd_stat ? bbe_pkg::EV_ZERO : irq_stat_q) | ev;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_mask_q <= bbe_pkg::EV_ZERO;
    end else if (bbe_wr(i_wb_adr, bbe_pkg::REG_IRQ_MASK, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack)
                 && i_wb_sel[0]) begin
      irq_mask_q <= i_wb_dat[bbe_pkg::NUM_EV-1:0];
    end
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

  //////////////////////////////////////////////////////////////////////
  // wishbone read and ack
  logic [31:0] rdat;

  always_comb begin
    case (i_wb_adr)
      bbe_pkg::REG_CTRL:     rdat = {24'h000000, ctrl_q[7:0]};
      bbe_pkg::REG_STATUS:   rdat = {25'h0000000, cfg_err, taught_v_q, fixed_on, o_blank_led,
                                     locked_q, trip, o_safe_out};
      bbe_pkg::REG_IRQ_STAT: rdat = {28'h0000000, irq_stat_q};
      bbe_pkg::REG_IRQ_MASK: rdat = {28'h0000000, irq_mask_q};
      bbe_pkg::REG_TAUGHT:   rdat = taught_q;
      bbe_pkg::REG_BEAMS:    rdat = beam_q;
      default:               rdat = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
      o_wb_dat <= (i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack) ? rdat : 32'h00000000;
    end
  end
endmodule : bbe_evaluator

// ### bench/bbe_checker.sv
// port assertions for the beam blanking evaluator
`timescale 1ns/100ps
module bbe_checker (
  input wire logic                          i_clk,
  input wire logic                          i_rst,
  input wire logic [bbe_pkg::NUM_BEAMS-1:0] i_beam_blocked,
  input wire logic                          i_wb_cyc,
  input wire logic                          i_wb_stb,
  input wire logic                          i_wb_we,
  input wire logic [bbe_pkg::AW-1:0]        i_wb_adr,
  input wire logic [31:0]                   i_wb_dat,
  input wire logic [3:0]                    i_wb_sel,
  input wire logic [31:0]                   o_wb_dat,
  input wire logic                          o_wb_ack,
  input wire logic                          o_safe_out,
  input wire logic                          o_blank_led,
  input wire logic                          o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic take_wr;
  assign take_wr = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_sel[0];
  property p_ack_next; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_one; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_cause; $rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle; !o_wb_ack |-> o_wb_dat == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_sync_beam; i_beam_blocked[0] |-> ##3 !o_safe_out; endproperty
  a_sync_beam: assert property (p_sync_beam) else $error("sync beam ignored");
  property p_safe_cause; $rose(o_safe_out) |-> !$past(i_beam_blocked[0], 3); endproperty
  a_safe_cause: assert property (p_safe_cause) else $error("enabled with sync beam cut");
  property p_cfg_off; take_wr && i_wb_adr == bbe_pkg::REG_CTRL && i_wb_dat[1:0] == 2'h3 |-> ##[1:4] !o_safe_out; endproperty
  a_cfg_off: assert property (p_cfg_off) else $error("illegal mode kept output on");
  property p_mask_quiet; take_wr && i_wb_adr == bbe_pkg::REG_IRQ_MASK && i_wb_dat[3:0] == 4'h0 |=> !o_irq; endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("masked irq raised");
  property p_led_hold; $fell(o_blank_led) |=> !o_blank_led; endproperty
  a_led_hold: assert property (p_led_hold) else $error("indicator flashes too fast");
endmodule : bbe_checker
bind bbe_evaluator bbe_checker u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_beam_blocked(i_beam_blocked),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
  .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_safe_out(o_safe_out),
  .o_blank_led(o_blank_led), .o_irq(o_irq));

// ### bench/bbe_emitter.sv
// emitter beam source and safety monitor with restart interlock
`timescale 1ns/100ps
module bbe_emitter (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [31:0] i_pattern,
  input  wire logic        i_safe,
  input  wire logic        i_restart,
  output logic      [31:0] o_beams,
  output logic             o_release
);
  logic tripped_q;
  always_ff @(posedge i_clk) o_beams <= i_pattern;
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst) tripped_q <= 1'h1;
    else tripped_q <= i_restart ? 1'h0 : (tripped_q | ~i_safe);
  assign o_release = i_safe & ~tripped_q;
endmodule : bbe_emitter

// ### bench/testbench.sv
// self-checking bench for the beam blanking evaluator
`timescale 1ns/100ps
module testbench;
  logic        i_clk = 1'h0, i_rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, restart = 1'h0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, pat = 32'h0, beams, rdat, rd;
  logic        ack, safe, led, irq, rel;
  int          n_errors = 0, cmp_count = 0;
  always #5 i_clk = ~i_clk;
  bbe_emitter u_emit (.i_clk(i_clk), .i_rst(i_rst), .i_pattern(pat), .i_safe(safe), .i_restart(restart),
    .o_beams(beams), .o_release(rel));
  // short flash period keeps the indicator observable
  bbe_evaluator #(.FLASH_PERIOD(4)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_beam_blocked(beams),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_safe_out(safe), .o_blank_led(led), .o_irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
    int n;
    @(posedge i_clk);
    {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, 4'hF};
    for (n = 0; n < 50 && ack !== 1'h1; n++) @(posedge i_clk);
    if (n == 50) begin
      n_errors++;
      summarize();
    end
    rd = rdat;
    {cyc, stb} <= 2'h0;
  endtask : wb
  task automatic rdchk(string name, logic [3:0] a, logic [31:0] exp);
    wb(1'h0, a, 32'h0);
    chk(name, exp, rd);
  endtask : rdchk
  // output flop lags the beams by three edges plus the source flop
  task automatic see(logic [31:0] p, logic exp);
    @(posedge i_clk);
    pat <= p;
    repeat (6) @(posedge i_clk);
    chk("safe", {31'h0, exp}, {31'h0, safe});
  endtask : see
  task automatic led_chk(int exp);
    int n;
    logic l;
    n = 0;
    l = led;
    repeat (16) begin
      @(posedge i_clk);
      if (led !== l) n++;
      l = led;
    end
    chk("led", exp, n);
  endtask : led_chk
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reg;
    rdchk("ctrl", bbe_pkg::REG_CTRL, 32'h0);
    rdchk("mask", bbe_pkg::REG_IRQ_MASK, 32'h0);
    wb(1'h1, 4'h7, 32'hFFFF_FFFF);
    rdchk("unmapped", 4'h7, 32'h0);
    see(32'h0, 1'h1);
    see(32'h20, 1'h0);
    see(32'h0, 1'h1);
    led_chk(0);
    chk("release", 32'h0, {31'h0, rel});
    @(posedge i_clk);
    restart <= 1'h1;
    @(posedge i_clk);
    restart <= 1'h0;
    @(posedge i_clk);
    chk("release", 32'h1, {31'h0, rel});
    see(32'h1, 1'h0);
    $display("test reg done");
  endtask : t_reg
  task automatic t_fixed;
    wb(1'h1, bbe_pkg::REG_CTRL, 32'h1);
    see(32'h418, 1'h0);
    wb(1'h1, bbe_pkg::REG_CTRL, 32'h101);
    rdchk("taught", bbe_pkg::REG_TAUGHT, 32'h418);
    see(32'h418, 1'h1);
    led_chk(4);
    see(32'h18, 1'h0);
    see(32'h418, 1'h0);
    wb(1'h1, bbe_pkg::REG_CTRL, 32'h101);
    see(32'h418, 1'h1);
    see(32'h518, 1'h0);
    $display("test fixed done");
  endtask : t_fixed
  task automatic t_edge;
    logic [31:0] ok[5] = '{32'hE0, 32'h38, 32'h30, 32'h60, 32'h70};
    see(32'h70, 1'h0);
    wb(1'h1, bbe_pkg::REG_CTRL, 32'h102);
    foreach (ok[i]) see(ok[i], 1'h1);
    wb(1'h1, bbe_pkg::REG_CTRL, 32'h3);
    see(32'h70, 1'h0);
    wb(1'h1, bbe_pkg::REG_CTRL, 32'hA);
    see(32'h70, 1'h0);
    wb(1'h1, bbe_pkg::REG_CTRL, 32'h102);
    see(32'h1C, 1'h0);
    see(32'hF0, 1'h0);
    wb(1'h1, bbe_pkg::REG_CTRL, 32'h102);
    see(32'hF0, 1'h1);
    $display("test edge done");
  endtask : t_edge
  task automatic t_float;
    wb(1'h1, bbe_pkg::REG_CTRL, 32'h8);
    see(32'h0010_0080, 1'h1);
    see(32'h0010_0088, 1'h0);
    wb(1'h1, bbe_pkg::REG_CTRL, 32'h4);
    see(32'h0010_0080, 1'h0);
    wb(1'h1, bbe_pkg::REG_CTRL, 32'h10);
    see(32'h400, 1'h0);
    wb(1'h1, bbe_pkg::REG_CTRL, 32'h18);
    see(32'h400, 1'h1);
    see(32'h0010_0400, 1'h0);
    wb(1'h1, bbe_pkg::REG_CTRL, 32'h9);
    wb(1'h1, bbe_pkg::REG_CTRL, 32'h109);
    see(32'h0010_0480, 1'h1);
    $display("test float done");
  endtask : t_float
  task automatic t_irq;
    wb(1'h1, bbe_pkg::REG_IRQ_MASK, 32'hF);
    wb(1'h0, bbe_pkg::REG_IRQ_STAT, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    see(32'h0010_0481, 1'h0);
    chk("irq", 32'h1, {31'h0, irq});
    rdchk("irq_stat", bbe_pkg::REG_IRQ_STAT, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    see(32'h0010_0480, 1'h1);
    see(32'h0010_0481, 1'h0);
    wb(1'h1, bbe_pkg::REG_IRQ_MASK, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test irq done");
  endtask : t_irq
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'h0;
    t_reg();
    t_fixed();
    t_edge();
    t_float();
    t_irq();
    summarize();
  end
endmodule : testbench
